// ### rtl/fce_pkg.sv
`default_nettype none
package fce_pkg;
	// Array layout: block 0 program flash, block 1 data EEPROM
	localparam int NUM_BLK = 2;
	localparam int BLK_W = 1;
	localparam int DIV_W = 7;
	// Command codes
	localparam logic [7:0] CMD_ERASE_VERIFY_ALL = 8'h01;
	localparam logic [7:0] CMD_VERIFY_BLOCK = 8'h02;
	localparam logic [7:0] CMD_PROGRAM = 8'h06;
	localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
	localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
	localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0A;
	// Algorithm lengths in mclk cycles
	localparam logic [9:0] PROG_CYC = 10'h040;
	localparam logic [9:0] ERASE_CYC = 10'h100;
	localparam logic [9:0] VERIFY_CYC = 10'h010;
	// Reset values
	localparam logic [DIV_W-1:0] DIV_RST = 7'h00;
	// Algorithm kinds
	typedef enum logic [1:0] {FCE_OP_PROG, FCE_OP_ERASE, FCE_OP_VERIFY, FCE_OP_VERIFY_ALL} fce_op_t;
endpackage
`default_nettype wire

// ### rtl/fce_eng_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fce_eng_if;
	logic start; // Launch pulse
	fce_pkg::fce_op_t op; // Algorithm kind
	logic [fce_pkg::BLK_W-1:0] blk; // Target block
	logic busy; // Algorithm running
	logic done; // Finish pulse
	logic all_erased; // Verify outcome
	modport ctrl (output start, output op, output blk, input busy, input done, input all_erased);
	modport eng (input start, input op, input blk, output busy, output done, output all_erased);
endinterface
`default_nettype wire

// ### rtl/fce_engine.sv
`timescale 1ns/1ps
`default_nettype none
module fce_engine (
	input wire logic mclk, // Clock
	input wire logic arst_n, // Async reset
	input wire logic [fce_pkg::NUM_BLK-1:0] blk_blank, // Per-block erased state from array
	fce_eng_if.eng eng // Controller link
);
	typedef enum logic [1:0] {FCE_IDLE, FCE_RUN, FCE_SCAN} fce_st_t;
	fce_st_t st;
	logic [9:0] cnt;
	logic [fce_pkg::BLK_W-1:0] scan_blk;
	logic blank_acc;
	logic scan_all; // Scan walks every block

	// The requested kind follows the live command code, so it is held at start

	// Algorithm sequencer
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st <= FCE_IDLE;
			cnt <= 10'h000;
			scan_blk <= '0;
			blank_acc <= 1'b0;
			scan_all <= 1'b0;
			eng.done <= 1'b0;
			eng.all_erased <= 1'b0;
		end else begin
			eng.done <= 1'b0;
			case (st)
				FCE_IDLE: begin
					if (eng.start) begin
						blank_acc <= 1'b1;
						scan_all <= (eng.op == fce_pkg::FCE_OP_VERIFY_ALL);
						if (eng.op == fce_pkg::FCE_OP_VERIFY_ALL) begin
							scan_blk <= '0;
							cnt <= fce_pkg::VERIFY_CYC;
							st <= FCE_SCAN;
						end else if (eng.op == fce_pkg::FCE_OP_VERIFY) begin
							scan_blk <= eng.blk;
							cnt <= fce_pkg::VERIFY_CYC;
							st <= FCE_SCAN;
						end else begin
							cnt <= (eng.op == fce_pkg::FCE_OP_PROG) ? fce_pkg::PROG_CYC : fce_pkg::ERASE_CYC;
							st <= FCE_RUN;
						end
					end
				end
				FCE_RUN: begin
					if (cnt == 10'h001) begin
						eng.done <= 1'b1;
						st <= FCE_IDLE;
					end
					cnt <= cnt - 10'h001;
				end
				FCE_SCAN: begin
					// Walk the target block, or every block when scan_all is set, one verify window each
					if (cnt == 10'h001) begin
						if (scan_all && scan_blk != fce_pkg::BLK_W'(fce_pkg::NUM_BLK - 1)) begin
							blank_acc <= blank_acc & blk_blank[scan_blk];
							scan_blk <= scan_blk + 1'b1;
							cnt <= fce_pkg::VERIFY_CYC;
						end else begin
							eng.all_erased <= blank_acc & blk_blank[scan_blk];
							eng.done <= 1'b1;
							st <= FCE_IDLE;
						end
					end else begin
						cnt <= cnt - 10'h001;
					end
				end
				default: st <= FCE_IDLE;
			endcase
		end
	end

	assign eng.busy = (st != FCE_IDLE);
endmodule
`default_nettype wire

// ### rtl/fce_ctrl.sv
// Overview of operation
// - Program/erase before divider write: error, no run
// - Invalid command code: set error, ignore command
// - Read of busy block flagged illegal
// - Verify-all checks every block for erased state
`timescale 1ns/1ps
`default_nettype none
module fce_ctrl (
	input wire logic mclk, // Clock, 50 MHz
	input wire logic arst_n, // Async reset, active low
	input wire logic div_wr, // Write strobe of flash_clock_divider
	input wire logic [fce_pkg::DIV_W-1:0] div_wdata, // Divider value
	input wire logic cmd_launch, // Command launch pulse
	input wire logic [7:0] cmd_code, // Command code
	input wire logic [fce_pkg::BLK_W-1:0] cmd_blk, // Target block
	input wire logic [fce_pkg::NUM_BLK-1:0] blk_protect, // Block protected
	input wire logic [fce_pkg::NUM_BLK-1:0] blk_blank, // Block erased
	input wire logic acc_err_clr, // Clear access_error_flag
	input wire logic prot_viol_clr, // Clear protection_violation_flag
	input wire logic rd_req, // Array read request
	input wire logic [fce_pkg::BLK_W-1:0] rd_blk, // Block being read
	output logic [fce_pkg::DIV_W-1:0] flash_clock_divider, // Divider register
	output logic div_done, // Divider written since reset
	output logic access_error_flag, // Sticky access error
	output logic protection_violation_flag, // Sticky protection violation
	output logic command_complete_flag, // High when idle
	output logic all_erased, // Last verify result
	output logic rd_illegal, // Pulse: read hit busy block
	output logic [fce_pkg::BLK_W-1:0] busy_blk // Block under algorithm
);
	fce_eng_if eif ();
	logic valid_cmd;
	logic needs_div;
	logic is_prog_erase;
	logic chk_prot;
	logic go;
	logic acc_evt;
	logic viol_evt;
	logic run_all; // Running command covers every block
	logic run_verify; // Running command is a verify
	fce_pkg::fce_op_t next_op;

	// Is the code one we run
	function automatic logic cmd_known(input logic [7:0] c);
		case (c)
			fce_pkg::CMD_ERASE_VERIFY_ALL, fce_pkg::CMD_VERIFY_BLOCK, fce_pkg::CMD_PROGRAM,
			fce_pkg::CMD_ERASE_ALL, fce_pkg::CMD_ERASE_BLOCK, fce_pkg::CMD_ERASE_SECTOR: cmd_known = 1'b1;
			default: cmd_known = 1'b0;
		endcase
	endfunction

	// Does the code alter the array
	function automatic logic cmd_modifies(input logic [7:0] c);
		case (c)
			fce_pkg::CMD_PROGRAM, fce_pkg::CMD_ERASE_ALL, fce_pkg::CMD_ERASE_BLOCK,
			fce_pkg::CMD_ERASE_SECTOR: cmd_modifies = 1'b1;
			default: cmd_modifies = 1'b0;
		endcase
	endfunction

	// Launch checks
	always_comb begin
		valid_cmd = cmd_known(cmd_code);
		is_prog_erase = cmd_modifies(cmd_code);
		needs_div = is_prog_erase && !div_done;
		chk_prot = is_prog_erase && (cmd_code == fce_pkg::CMD_ERASE_ALL ? |blk_protect : blk_protect[cmd_blk]);
		case (cmd_code)
			fce_pkg::CMD_PROGRAM: next_op = fce_pkg::FCE_OP_PROG;
			fce_pkg::CMD_ERASE_VERIFY_ALL: next_op = fce_pkg::FCE_OP_VERIFY_ALL;
			fce_pkg::CMD_VERIFY_BLOCK: next_op = fce_pkg::FCE_OP_VERIFY;
			default: next_op = fce_pkg::FCE_OP_ERASE;
		endcase
		acc_evt = 1'b0;
		viol_evt = 1'b0;
		go = 1'b0;
		if (cmd_launch) begin
			if (!command_complete_flag || eif.busy || access_error_flag || protection_violation_flag) begin
				acc_evt = 1'b1;
			end else if (!valid_cmd) begin
				acc_evt = 1'b1;
			end else if (needs_div) begin
				acc_evt = 1'b1;
			end else if (chk_prot) begin
				viol_evt = 1'b1;
			end else begin
				go = 1'b1;
			end
		end
	end

	// Engine request
	assign eif.start = go;
	assign eif.op = next_op;
	assign eif.blk = cmd_blk;

	// Clock divider register and its written marker
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			flash_clock_divider <= fce_pkg::DIV_RST;
			div_done <= 1'b0;
		end else if (div_wr && command_complete_flag) begin
			flash_clock_divider <= div_wdata;
			div_done <= 1'b1;
		end
	end

	// Sticky error flags; a new event wins over a clear
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			access_error_flag <= 1'b0;
			protection_violation_flag <= 1'b0;
		end else begin
			if (acc_evt) begin
				access_error_flag <= 1'b1;
			end else if (acc_err_clr) begin
				access_error_flag <= 1'b0;
			end
			if (viol_evt) begin
				protection_violation_flag <= 1'b1;
			end else if (prot_viol_clr) begin
				protection_violation_flag <= 1'b0;
			end
		end
	end

	// Command complete and busy block tracking; the running command's scope is held
	// here because the engine request follows the live command code
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			command_complete_flag <= 1'b1;
			busy_blk <= '0;
			run_all <= 1'b0;
			run_verify <= 1'b0;
		end else if (go) begin
			command_complete_flag <= 1'b0;
			busy_blk <= cmd_blk;
			run_all <= (next_op == fce_pkg::FCE_OP_VERIFY_ALL) || (cmd_code == fce_pkg::CMD_ERASE_ALL);
			run_verify <= (next_op == fce_pkg::FCE_OP_VERIFY_ALL) || (next_op == fce_pkg::FCE_OP_VERIFY);
		end else if (eif.done) begin
			command_complete_flag <= 1'b1;
		end
	end

	// Verify result capture
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			all_erased <= 1'b0;
		end else if (eif.done && run_verify) begin
			all_erased <= eif.all_erased;
		end
	end

	// Reads that collide with a running algorithm
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rd_illegal <= 1'b0;
		end else begin
			rd_illegal <= rd_req && !command_complete_flag && (run_all || rd_blk == busy_blk);
		end
	end

	fce_engine u_eng (
		.mclk(mclk),
		.arst_n(arst_n),
		.blk_blank(blk_blank),
		.eng(eif)
	);
endmodule
`default_nettype wire

// ### sim/fce_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fce_ctrl_chk (
	input wire logic mclk, // Clock
	input wire logic arst_n, // Reset
	input wire logic cmd_launch, // Launch
	input wire logic [7:0] cmd_code, // Code
	input wire logic [fce_pkg::BLK_W-1:0] cmd_blk, // Target
	input wire logic [fce_pkg::NUM_BLK-1:0] blk_protect, // Protect
	input wire logic rd_req, // Read
	input wire logic [fce_pkg::BLK_W-1:0] rd_blk, // Read block
	input wire logic div_done, // Divider set
	input wire logic access_error_flag, // Error
	input wire logic protection_violation_flag, // Violation
	input wire logic command_complete_flag, // Idle
	input wire logic all_erased, // Verify result
	input wire logic rd_illegal, // Read hit
	input wire logic [fce_pkg::BLK_W-1:0] busy_blk // Busy block
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	logic idle_ok;
	logic pe;
	logic code_ok;
	// Launch qualifiers
	assign idle_ok = command_complete_flag && !access_error_flag && !protection_violation_flag;
	assign pe = cmd_code inside {fce_pkg::CMD_PROGRAM, fce_pkg::CMD_ERASE_ALL, fce_pkg::CMD_ERASE_BLOCK,
		fce_pkg::CMD_ERASE_SECTOR};
	assign code_ok = pe || cmd_code inside {fce_pkg::CMD_ERASE_VERIFY_ALL, fce_pkg::CMD_VERIFY_BLOCK};
	no_div_err_a: assert property (cmd_launch && idle_ok && !div_done && pe |=>
		access_error_flag && command_complete_flag) else $error("launch before divider ran");
	bad_code_a: assert property (cmd_launch && idle_ok && !code_ok |=>
		access_error_flag && command_complete_flag) else $error("invalid code ran");
	err_cause_a: assert property ($rose(access_error_flag) |-> $past(cmd_launch)) else $error("error without launch");
	rd_busy_a: assert property (rd_req && !command_complete_flag && rd_blk == busy_blk |=> rd_illegal)
		else $error("busy read not flagged");
	rd_quiet_a: assert property (!rd_req |=> !rd_illegal) else $error("read flag without read");
	run_len_a: assert property (cmd_launch && idle_ok && div_done && cmd_code == fce_pkg::CMD_PROGRAM &&
		!blk_protect[cmd_blk] |=> !command_complete_flag [*8] ##57 !command_complete_flag ##1 command_complete_flag)
		else $error("program run length wrong");
	fall_cause_a: assert property ($fell(command_complete_flag) |-> $past(cmd_launch))
		else $error("complete flag fell alone");
	verify_upd_a: assert property ($changed(all_erased) |-> $rose(command_complete_flag))
		else $error("verify result moved mid run");
endmodule
bind fce_ctrl fce_ctrl_chk chk (.mclk, .arst_n, .cmd_launch, .cmd_code, .cmd_blk, .blk_protect, .rd_req, .rd_blk,
	.div_done, .access_error_flag, .protection_violation_flag, .command_complete_flag, .all_erased, .rd_illegal,
	.busy_blk);
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic mclk, arst_n, div_wr, cmd_launch, acc_err_clr, prot_viol_clr, rd_req;
	logic [6:0] div_wdata, flash_clock_divider;
	logic [7:0] cmd_code;
	logic [0:0] cmd_blk, rd_blk, busy_blk;
	logic [1:0] blk_protect, blk_blank;
	logic div_done, access_error_flag, protection_violation_flag, command_complete_flag, all_erased, rd_illegal;
	int fails, checks_done;
	logic [7:0] pe [4] = '{fce_pkg::CMD_PROGRAM, fce_pkg::CMD_ERASE_ALL, fce_pkg::CMD_ERASE_BLOCK,
		fce_pkg::CMD_ERASE_SECTOR};
	logic [7:0] bad [3] = '{8'h00, 8'h03, 8'hFF};
	logic [1:0] blanks [3] = '{2'b11, 2'b01, 2'b10};
	fce_ctrl dut (.mclk, .arst_n, .div_wr, .div_wdata, .cmd_launch, .cmd_code, .cmd_blk, .blk_protect, .blk_blank,
		.acc_err_clr, .prot_viol_clr, .rd_req, .rd_blk, .flash_clock_divider, .div_done, .access_error_flag,
		.protection_violation_flag, .command_complete_flag, .all_erased, .rd_illegal, .busy_blk);
	// Free running clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic finish_test();
		if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	// Error, violation and complete flags together
	task automatic flags(input logic [2:0] exp, input string what);
		chk(8'({access_error_flag, protection_violation_flag, command_complete_flag}), 8'(exp), what);
	endtask
	task automatic launch(input logic [7:0] c, input logic [0:0] b);
		@(posedge mclk);
		cmd_launch <= 1'b1;
		cmd_code <= c;
		cmd_blk <= b;
		@(posedge mclk);
		cmd_launch <= 1'b0;
		#1;
	endtask
	task automatic clear();
		@(posedge mclk);
		acc_err_clr <= 1'b1;
		prot_viol_clr <= 1'b1;
		@(posedge mclk);
		acc_err_clr <= 1'b0;
		prot_viol_clr <= 1'b0;
	endtask
	task automatic rd(input logic [0:0] b, input logic exp);
		@(posedge mclk);
		rd_req <= 1'b1;
		rd_blk <= b;
		@(posedge mclk);
		rd_req <= 1'b0;
		#1 chk(8'(rd_illegal), 8'(exp), "read check");
	endtask
	// Bounded wait for the algorithm to finish
	task automatic wait_idle();
		int n;
		n = 0;
		while (command_complete_flag !== 1'b1 && n < 600) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 600) begin
			fails++;
			$display("unexpected %0t command hang", $time);
			finish_test();
		end
	endtask
	initial begin
		{arst_n, div_wr, div_wdata, cmd_launch, cmd_code, cmd_blk, acc_err_clr, prot_viol_clr, rd_req, rd_blk} = '0;
		blk_protect = 2'b00;
		blk_blank = 2'b11;
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		flags(3'b001, "reset flags");
		chk(8'({div_done, flash_clock_divider}), 8'h00, "reset divider");
		// Modifying commands before the divider is written
		foreach (pe[i]) begin
			launch(pe[i], 1'b0);
			flags(3'b101, "no divider");
			clear();
		end
		@(posedge mclk);
		div_wr <= 1'b1;
		div_wdata <= 7'h13;
		@(posedge mclk);
		div_wr <= 1'b0;
		#1 chk(8'({div_done, flash_clock_divider}), 8'h93, "divider");
		// Undefined codes are refused
		foreach (bad[i]) begin
			launch(bad[i], 1'b0);
			flags(3'b101, "bad code");
			clear();
		end
		// Program run with reads against both blocks
		launch(fce_pkg::CMD_PROGRAM, 1'b0);
		flags(3'b000, "launch");
		rd(1'b0, 1'b1);
		rd(1'b1, 1'b0);
		wait_idle();
		flags(3'b001, "finish");
		// Verify all over the blank patterns 11, 01 and 10
		foreach (blanks[i]) begin
			@(posedge mclk);
			blk_blank <= blanks[i];
			launch(fce_pkg::CMD_ERASE_VERIFY_ALL, 1'b0);
			rd(1'b1, 1'b1);
			wait_idle();
			chk(8'(all_erased), 8'(&blanks[i]), "verify all");
		end
		// Verify of one block, reads of both blocks
		@(posedge mclk);
		blk_blank <= 2'b10;
		launch(fce_pkg::CMD_VERIFY_BLOCK, 1'b1);
		chk(8'(busy_blk), 8'h01, "busy block");
		rd(1'b1, 1'b1);
		rd(1'b0, 1'b0);
		wait_idle();
		chk(8'(all_erased), 8'h01, "verify block");
		// Erase of all blocks guards every block; a launch while busy is refused
		launch(fce_pkg::CMD_ERASE_ALL, 1'b0);
		flags(3'b000, "erase all");
		rd(1'b1, 1'b1);
		launch(fce_pkg::CMD_PROGRAM, 1'b0);
		flags(3'b100, "busy launch");
		wait_idle();
		flags(3'b101, "erase done");
		clear();
		// Erase of a protected block
		@(posedge mclk);
		blk_protect <= 2'b10;
		launch(fce_pkg::CMD_ERASE_BLOCK, 1'b1);
		flags(3'b011, "protected");
		clear();
		#1 flags(3'b001, "cleared");
		// A second reset drops the divider marker again
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		#1 flags(3'b001, "second reset flags");
		chk(8'({div_done, flash_clock_divider}), 8'h00, "second reset divider");
		launch(fce_pkg::CMD_ERASE_SECTOR, 1'b0);
		flags(3'b101, "no divider after reset");
		finish_test();
	end
endmodule
`default_nettype wire
